/* File: logic/sdp_regs.svh */
`ifndef SDP_REGS_SVH
`define SDP_REGS_SVH
// What this block does
// [R1] Address byte is fixed 010100 then two strap bits; mismatching frames are ignored.
// [R2] Read wiper (1001, select 00) replies 00 plus the chosen wiper position.
// [R3] Write wiper (1010, select 00) loads the data byte's low six bits.
// [R4] Read setting (1011) replies the saved setting picked by select and pot bits.
// [R5] Write setting (1100) stores the data byte's low six bits, nonvolatile write after chip select rises.
// [R6] Read status (0101) replies 00, zeros and the write-in-progress flag in bit 0.
// [R7] Transfer (1101) copies the chosen saved setting into that pot's wiper; two bytes.
// [R8] Store (1110) copies the pot's wiper into the chosen saved setting, then writes.
// [R9] Global recall (0001) loads every wiper from its chosen saved setting.
// [R10] Global store (1000) copies every wiper into its chosen saved setting, then writes.
// [R11] Step (0010, select 00) takes any number of step bits until chip select rises.
// [R12] A step bit of one moves the wiper up one tap toward the high terminal.
// [R13] A step bit of zero moves the wiper down one tap toward the low terminal.
// [R14] Nonvolatile programming starts only after chip select returns high.
// [R15] Select bits 00, 01, 10, 11 pick saved settings zero to three.
// [R16] Write-in-progress flag is one while the nonvolatile write runs, else zero.
// [R17] A nonvolatile write finishes within 5 ms of its start.
// [R18] After reset each wiper loads from its pot's saved setting zero.
// [R19] Steps past tap 0 or tap 63 leave the wiper at that end.
// [R20] Mismatched or broken-byte frames change no register, except that a broken step frame keeps the steps already taken.
// [R21] Setting writes are ignored while a nonvolatile write is running.
`define SDP_ADDR_FIXED 6'h14
`define SDP_OP_RD_WIPER 4'h9
`define SDP_OP_WR_WIPER 4'ha
`define SDP_OP_RD_SET 4'hb
`define SDP_OP_WR_SET 4'hc
`define SDP_OP_XFR 4'hd
`define SDP_OP_STORE 4'he
`define SDP_OP_GXFR 4'h1
`define SDP_OP_GSTORE 4'h8
`define SDP_OP_STEP 4'h2
`define SDP_OP_STATUS 4'h5
`define SDP_SEL_ZERO 2'h0
`define SDP_PAD_ZERO 2'h0
`define SDP_STATUS_PAD 7'h00
`define SDP_POS_MAX 6'h3f
`define SDP_POS_MIN 6'h00
`define SDP_SETTING_RESET 6'h00
`define SDP_BIT_LAST 3'h7
`define SDP_NV_WRITE_NS 5000000
`define SDP_CLK_PERIOD_NS 4
`endif

/* File: logic/sdp_pkg.sv */
`include "sdp_regs.svh"
package sdp_pkg;
    typedef logic [5:0] sdp_pos_t;
    typedef sdp_pos_t [1:0] sdp_wipers_t;
    typedef enum logic [3:0] {
        OP_RD_WIPER = `SDP_OP_RD_WIPER,
        OP_WR_WIPER = `SDP_OP_WR_WIPER,
        OP_RD_SET = `SDP_OP_RD_SET,
        OP_WR_SET = `SDP_OP_WR_SET,
        OP_XFR = `SDP_OP_XFR,
        OP_STORE = `SDP_OP_STORE,
        OP_GXFR = `SDP_OP_GXFR,
        OP_GSTORE = `SDP_OP_GSTORE,
        OP_STEP = `SDP_OP_STEP,
        OP_STATUS = `SDP_OP_STATUS
    } sdp_op_e;
    typedef struct packed {
        sdp_op_e opcode;
        logic [1:0] sel;
        logic spare;
        logic pot;
    } sdp_cmd_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_INSTR = 2'b11,
        ST_DATA = 2'b10
    } sdp_state_e;
endpackage

/* File: logic/sdp_nv_timer.sv */
`timescale 1ns/1ps
module sdp_nv_timer #(
    parameter int CYCLES = 1250000,
    parameter int CNT_W = 21
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Control
    input wire logic start_in,
    output logic busy_out
);
    logic [CNT_W-1:0] cnt_q;

    initial begin
        if (CYCLES < 1 || CYCLES >= (2 ** CNT_W)) begin
            $error("sdp_nv_timer: CYCLES does not fit CNT_W");
        end
    end

    // Busy ends when the count runs out; a start while busy is refused upstream
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_q <= '0;
            busy_out <= 1'b0;
        end else if (start_in && !busy_out) begin
            cnt_q <= CNT_W'(CYCLES - 1);
            busy_out <= 1'b1;
        end else if (busy_out) begin
            cnt_q <= cnt_q - CNT_W'(1);
            busy_out <= (cnt_q != '0);
        end
    end
endmodule

/* File: logic/sdp_decoder.sv */
`timescale 1ns/1ps
`include "sdp_regs.svh"
module sdp_decoder #(
    parameter int NV_WRITE_CYCLES = `SDP_NV_WRITE_NS / `SDP_CLK_PERIOD_NS, // [R17]
    parameter int NV_CNT_W = 21
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Serial bus pins
    input wire logic sck_in,
    input wire logic cs_b_in,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe_out,
    // Strap pins
    input wire logic strap_addr_hi_in,
    input wire logic strap_addr_lo_in,
    // Pot state
    output sdp_pkg::sdp_wipers_t wiper_pos_out,
    output logic write_in_progress_out
);
    import sdp_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] pin_w, sync1_q, sync2_q;
    logic sck_d_q;
    assign pin_w = {strap_addr_lo_in, strap_addr_hi_in, si_in, cs_b_in, sck_in};

    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge clock_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                sync1_q[i] <= 1'b1;
                sync2_q[i] <= 1'b1;
            end else begin
                sync1_q[i] <= pin_w[i];
                sync2_q[i] <= sync1_q[i];
            end
        end
    end

    logic cs_d_q;
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sck_d_q <= 1'b1;
            cs_d_q <= 1'b1;
        end else begin
            sck_d_q <= sync2_q[0];
            cs_d_q <= sync2_q[1];
        end
    end

    wire logic sck_w = sync2_q[0];
    wire logic cs_b_w = sync2_q[1];
    wire logic si_w = sync2_q[2];
    wire logic [1:0] strap_w = {sync2_q[3], sync2_q[4]};
    wire logic cs_fall_w = cs_d_q & ~cs_b_w;
    wire logic cs_rise_w = ~cs_d_q & cs_b_w;
    wire logic sck_rise_w = ~cs_b_w & ~sck_d_q & sck_w;
    wire logic sck_fall_w = ~cs_b_w & sck_d_q & ~sck_w;

    // ----------------------------------------
    // Frame state
    // ----------------------------------------
    sdp_state_e state_q;
    logic [2:0] bit_cnt_q;
    logic [1:0] data_bytes_q;
    logic frame_bad_q;
    logic [7:0] rx_q, data_q, tx_q;
    sdp_cmd_s cmd_q;
    sdp_pos_t wiper_q [2];
    sdp_pos_t saved_q [2][4];
    logic init_done_q;
    logic nv_busy_w;

    wire logic [7:0] rx_w = {rx_q[6:0], si_w};
    wire logic byte_end_w = sck_rise_w && (bit_cnt_q == `SDP_BIT_LAST);
    wire sdp_cmd_s cmd_nxt_w = sdp_cmd_s'(rx_w);
    wire logic addr_ok_w = (rx_w == {`SDP_ADDR_FIXED, strap_w}); // [R1]

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= '0;
            data_bytes_q <= '0;
            frame_bad_q <= 1'b0;
            rx_q <= '0;
            data_q <= '0;
            cmd_q <= '0;
        end else if (cs_fall_w) begin
            state_q <= ST_ADDR;
            bit_cnt_q <= '0;
            data_bytes_q <= '0;
            frame_bad_q <= 1'b0;
        end else if (cs_rise_w) begin
            state_q <= ST_IDLE;
        end else if (sck_rise_w && state_q != ST_IDLE) begin
            rx_q <= rx_w;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_end_w) begin
                case (state_q)
                    ST_ADDR: begin
                        frame_bad_q <= ~addr_ok_w; // [R1] [R20]
                        state_q <= ST_INSTR;
                    end
                    ST_INSTR: begin
                        cmd_q <= cmd_nxt_w;
                        state_q <= ST_DATA;
                    end
                    ST_DATA: begin
                        data_q <= rx_w;
                        if (data_bytes_q != 2'h3) begin
                            data_bytes_q <= data_bytes_q + 2'h1;
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // Commands other than step and the reads act only on a clean byte boundary at chip select rise; step acts on each clock rise
    wire logic exec_w = cs_rise_w && !frame_bad_q && state_q == ST_DATA && bit_cnt_q == '0; // [R20]
    wire logic two_byte_w = exec_w && data_bytes_q == 2'h0;
    wire logic three_byte_w = exec_w && data_bytes_q == 2'h1;
    wire logic sel0_w = cmd_q.sel == `SDP_SEL_ZERO;
    wire logic do_wr_wiper_w = three_byte_w && cmd_q.opcode == OP_WR_WIPER && sel0_w; // [R3]
    wire logic do_xfr_w = two_byte_w && cmd_q.opcode == OP_XFR; // [R7]
    wire logic do_gxfr_w = two_byte_w && cmd_q.opcode == OP_GXFR; // [R9]
    wire logic do_wr_set_w = three_byte_w && cmd_q.opcode == OP_WR_SET && !nv_busy_w; // [R5] [R21]
    wire logic do_store_w = two_byte_w && cmd_q.opcode == OP_STORE && !nv_busy_w; // [R8] [R21]
    wire logic do_gstore_w = two_byte_w && cmd_q.opcode == OP_GSTORE && !nv_busy_w; // [R10] [R21]
    wire logic nv_start_w = do_wr_set_w | do_store_w | do_gstore_w; // [R14]
    wire logic stepping_w = state_q == ST_DATA && !frame_bad_q && cmd_q.opcode == OP_STEP && sel0_w; // [R11]
    wire logic step_w = sck_rise_w && stepping_w;

    // ----------------------------------------
    // Wiper and saved settings
    // ----------------------------------------
    for (genvar p = 0; p < 2; p++) begin : g_pot
        wire logic hit_w = cmd_q.pot == 1'(p);
        wire sdp_pos_t cur_w = wiper_q[p];
        wire logic up_ok_w = cur_w != `SDP_POS_MAX; // [R19]
        wire logic dn_ok_w = cur_w != `SDP_POS_MIN; // [R19]
        always_ff @(posedge clock_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
                wiper_q[p] <= `SDP_SETTING_RESET;
            end else if (!init_done_q) begin
                wiper_q[p] <= saved_q[p][0]; // [R18]
            end else if (step_w && hit_w) begin
                if (si_w && up_ok_w) begin
                    wiper_q[p] <= cur_w + 6'h01; // [R12]
                end else if (!si_w && dn_ok_w) begin
                    wiper_q[p] <= cur_w - 6'h01; // [R13]
                end
            end else if (do_wr_wiper_w && hit_w) begin
                wiper_q[p] <= data_q[5:0]; // [R3]
            end else if ((do_xfr_w && hit_w) || do_gxfr_w) begin
                wiper_q[p] <= saved_q[p][cmd_q.sel]; // [R7] [R9] [R15]
            end
        end
        for (genvar s = 0; s < 4; s++) begin : g_set
            wire logic sel_hit_w = cmd_q.sel == 2'(s); // [R15]
            always_ff @(posedge clock_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    saved_q[p][s] <= `SDP_SETTING_RESET;
                end else if (do_wr_set_w && hit_w && sel_hit_w) begin
                    saved_q[p][s] <= data_q[5:0]; // [R5]
                end else if (((do_store_w && hit_w) || do_gstore_w) && sel_hit_w) begin
                    saved_q[p][s] <= cur_w; // [R8] [R10]
                end
            end
        end
        assign wiper_pos_out[p] = wiper_q[p];
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            init_done_q <= 1'b0;
        end else begin
            init_done_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Nonvolatile write timer
    // ----------------------------------------
    sdp_nv_timer #(
        .CYCLES(NV_WRITE_CYCLES),
        .CNT_W(NV_CNT_W)
    ) u_nv_timer (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .start_in(nv_start_w),
        .busy_out(nv_busy_w)
    );
    assign write_in_progress_out = nv_busy_w; // [R16]

    // ----------------------------------------
    // Reply shifter
    // ----------------------------------------
    wire sdp_pos_t reply_wiper_w = wiper_q[cmd_nxt_w.pot];
    wire sdp_pos_t reply_set_w = saved_q[cmd_nxt_w.pot][cmd_nxt_w.sel];
    wire logic nxt_sel0_w = cmd_nxt_w.sel == `SDP_SEL_ZERO;
    wire logic [7:0] reply_w =
        frame_bad_q ? '0 :
        (cmd_nxt_w.opcode == OP_RD_WIPER && nxt_sel0_w) ? {`SDP_PAD_ZERO, reply_wiper_w} : // [R2]
        (cmd_nxt_w.opcode == OP_RD_SET) ? {`SDP_PAD_ZERO, reply_set_w} : // [R4]
        (cmd_nxt_w.opcode == OP_STATUS) ? {`SDP_STATUS_PAD, nv_busy_w} : '0; // [R6]

    // Data leaves on falling edges so it is settled before the host samples
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_q <= '0;
            so_out <= 1'b0;
            so_oe_out <= 1'b0;
        end else if (cs_fall_w || cs_rise_w) begin
            tx_q <= '0;
            so_out <= 1'b0;
            so_oe_out <= cs_fall_w;
        end else if (byte_end_w && state_q == ST_INSTR) begin
            tx_q <= reply_w;
        end else if (sck_fall_w) begin
            so_out <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    wire logic reply_load_w = byte_end_w && state_q == ST_INSTR && !frame_bad_q;

    sequence s_bad_end;
        frame_bad_q && cs_rise_w;
    endsequence

    chk_addr_gate_ignore: assert property ( // [R1]
        s_bad_end |=> $stable(wiper_q[0]) && $stable(saved_q[1][0]))
        else $error("bad address frame changed a register");
    chk_read_wiper_reply: assert property ( // [R2]
        reply_load_w && cmd_nxt_w.opcode == OP_RD_WIPER && nxt_sel0_w |=> tx_q == {2'b00, $past(reply_wiper_w)})
        else $error("read wiper reply wrong");
    chk_write_wiper_load: assert property ( // [R3]
        do_wr_wiper_w && init_done_q && !cmd_q.pot |=> wiper_q[0] == $past(data_q[5:0]))
        else $error("write wiper did not load");
    chk_read_setting_reply: assert property ( // [R4]
        reply_load_w && cmd_nxt_w.opcode == OP_RD_SET |=> tx_q[7:6] == 2'b00 && tx_q[5:0] == $past(reply_set_w))
        else $error("read setting reply wrong");
    chk_status_reply: assert property ( // [R6]
        reply_load_w && cmd_nxt_w.opcode == OP_STATUS |=> tx_q == {7'h00, $past(nv_busy_w)})
        else $error("status reply wrong");
    chk_nv_start_csrise: assert property ($rose(nv_busy_w) |-> $past(cs_rise_w)) // [R14]
        else $error("nonvolatile write started without chip select rise");
    chk_nv_busy_ignore: assert property ( // [R21]
        nv_busy_w && cs_rise_w |=> $stable(saved_q[0][0]) && $stable(saved_q[1][1]) && $stable(saved_q[1][3]))
        else $error("setting written while busy");
    chk_step_up_sat: assert property ( // [R12]
        step_w && !cmd_q.pot && si_w && init_done_q
        |=> wiper_q[0] == (($past(wiper_q[0]) == 6'h3f) ? 6'h3f : $past(wiper_q[0]) + 6'h01))
        else $error("step up wrong");
    chk_step_down_sat: assert property ( // [R13]
        step_w && cmd_q.pot && !si_w && init_done_q
        |=> wiper_q[1] == (($past(wiper_q[1]) == 6'h00) ? 6'h00 : $past(wiper_q[1]) - 6'h01))
        else $error("step down wrong");
    chk_powerup_recall: assert property (!init_done_q |=> wiper_q[1] == $past(saved_q[1][0])) // [R18]
        else $error("power-up recall missed");
endmodule

/* File: verif/sdp_spi_host.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Serial host model, mode 0, 125 ns bit period on average
// ------------------------------------------------------------
module sdp_spi_host (
    // Clock
    input wire logic clock_in,
    // Serial bus
    output logic sck_out,
    output logic cs_b_out,
    output logic si_out,
    input wire logic so_in,
    input wire logic so_oe_in
);
    // Released data line floats high through its pull-up
    wire logic so_line_w = so_oe_in ? so_in : 1'b1;

    initial begin
        sck_out = 1'b0;
        cs_b_out = 1'b1;
        si_out = 1'b0;
    end

    // Bits leave MSB first from the top of tx; rx keeps the last eight sampled
    task automatic xfer(input logic [31:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        @(posedge clock_in);
        cs_b_out <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            si_out <= tx[31 - i];
            repeat (15) @(posedge clock_in);
            sck_out <= 1'b1;
            rx = {rx[6:0], so_line_w};
            // 31 clocks a bit, 32 every fourth: 500 ns per four bits
            repeat ((i % 4 == 3) ? 17 : 16) @(posedge clock_in);
            sck_out <= 1'b0;
        end
        repeat (6) @(posedge clock_in);
        cs_b_out <= 1'b1;
        // Released line must not keep the last bit
        si_out <= ~si_out;
        repeat (8) @(posedge clock_in);
    endtask
endmodule

/* File: verif/tb_sdp_decoder.sv */
`timescale 1ns/1ps
`include "sdp_regs.svh"
module tb_sdp_decoder;
    import sdp_pkg::*;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    // Short write cycle keeps the run brief
    localparam int NV_CYC = 2000;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic sck, cs_b, si, so_out, so_oe_out, write_in_progress_out;
    logic strap_hi = 1'b1;
    logic strap_lo = 1'b0;
    logic [1:0] strap_tx = 2'b10;
    sdp_wipers_t wiper_pos_out;
    int num_errors = 0;
    int n_compared = 0;
    logic [7:0] rx;

    always #2 clock_in = ~clock_in;

    sdp_decoder #(.NV_WRITE_CYCLES(NV_CYC)) i_sdp_decoder (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .sck_in(sck), .cs_b_in(cs_b), .si_in(si),
        .so_out(so_out), .so_oe_out(so_oe_out), .strap_addr_hi_in(strap_hi),
        .strap_addr_lo_in(strap_lo), .wiper_pos_out(wiper_pos_out),
        .write_in_progress_out(write_in_progress_out)
    );
    sdp_spi_host i_sdp_spi_host (
        .clock_in(clock_in), .sck_out(sck), .cs_b_out(cs_b), .si_out(si), .so_in(so_out),
        .so_oe_in(so_oe_out)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t reply %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pos(input int pot, input sdp_pos_t exp);
        n_compared++;
        if (wiper_pos_out[pot] !== exp) begin
            num_errors++;
            $display("[FAIL] %0t wiper %0d is %h expected %h", $time, pot, wiper_pos_out[pot], exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t busy flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [3:0] op, input logic [1:0] sel, input logic pot,
                       input logic [7:0] data, input int nbits);
        i_sdp_spi_host.xfer({`SDP_ADDR_FIXED, strap_tx, op, sel, 1'b0, pot, data, 8'h00}, nbits, rx);
    endtask

    // Bounded wait for the write cycle to end
    task automatic wait_idle();
        int n;
        for (n = 0; n < NV_CYC + 100 && write_in_progress_out !== 1'b0; n++) @(posedge clock_in);
        n_compared++;
        if (n >= NV_CYC + 100) begin
            num_errors++;
            $display("[FAIL] %0t write cycle did not end", $time);
        end
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock_in);
        rst_b_in <= 1'b1;
        repeat (6) @(posedge clock_in);
        chk_pos(0, 6'h00);
        chk_pos(1, 6'h00);
        cmd(OP_WR_WIPER, 2'h0, 1'b0, 8'h15, 24);
        cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h2a, 24);
        chk_pos(0, 6'h15);
        chk_pos(1, 6'h2a);
        cmd(OP_RD_WIPER, 2'h0, 1'b1, 8'h00, 24);
        chk_byte(rx, 8'h2a);
        // Wrong strap bits: no write and an all-zero reply
        strap_tx = ~strap_tx;
        cmd(OP_WR_WIPER, 2'h0, 1'b0, 8'h3f, 24);
        cmd(OP_RD_WIPER, 2'h0, 1'b1, 8'h00, 24);
        strap_tx = ~strap_tx;
        chk_byte(rx, 8'h00);
        chk_pos(0, 6'h15);
        cmd(OP_WR_WIPER, 2'h0, 1'b0, 8'h3f, 20);
        chk_pos(0, 6'h15);
        for (int s = 0; s < 4; s++) begin
            cmd(OP_WR_SET, s[1:0], 1'b0, 8'h08 + s[7:0], 24);
            chk_flag(write_in_progress_out, 1'b1);
            wait_idle();
        end
        for (int s = 0; s < 4; s++) begin
            cmd(OP_RD_SET, s[1:0], 1'b0, 8'h00, 24);
            chk_byte(rx, 8'h08 + s[7:0]);
        end
        cmd(OP_WR_SET, 2'h2, 1'b1, 8'h33, 24);
        cmd(OP_STATUS, 2'h0, 1'b1, 8'h00, 24);
        chk_byte(rx, 8'h01);
        cmd(OP_WR_SET, 2'h1, 1'b1, 8'h22, 24);
        wait_idle();
        cmd(OP_STATUS, 2'h0, 1'b1, 8'h00, 24);
        chk_byte(rx, 8'h00);
        cmd(OP_RD_SET, 2'h1, 1'b1, 8'h00, 24);
        chk_byte(rx, 8'h00);
        cmd(OP_RD_SET, 2'h2, 1'b1, 8'h00, 24);
        chk_byte(rx, 8'h33);
        cmd(OP_XFR, 2'h3, 1'b0, 8'h00, 16);
        chk_pos(0, 6'h0b);
        cmd(OP_STORE, 2'h3, 1'b1, 8'h00, 16);
        chk_flag(write_in_progress_out, 1'b1);
        wait_idle();
        cmd(OP_RD_SET, 2'h3, 1'b1, 8'h00, 24);
        chk_byte(rx, 8'h2a);
        cmd(OP_GXFR, 2'h2, 1'b0, 8'h00, 16);
        chk_pos(0, 6'h0a);
        chk_pos(1, 6'h33);
        cmd(OP_GSTORE, 2'h1, 1'b0, 8'h00, 16);
        chk_flag(write_in_progress_out, 1'b1);
        wait_idle();
        cmd(OP_RD_SET, 2'h1, 1'b0, 8'h00, 24);
        chk_byte(rx, 8'h0a);
        cmd(OP_RD_SET, 2'h1, 1'b1, 8'h00, 24);
        chk_byte(rx, 8'h33);
        // Up twice at the top end, then down three times
        cmd(OP_WR_WIPER, 2'h0, 1'b0, 8'h3e, 24);
        cmd(OP_STEP, 2'h0, 1'b0, 8'hc0, 21);
        chk_pos(0, 6'h3c);
        // Down twice at the bottom end, then up once
        cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h01, 24);
        cmd(OP_STEP, 2'h0, 1'b1, 8'h20, 19);
        chk_pos(1, 6'h01);
        report_and_stop();
    end

    // About thirty frames under 800 clocks each plus seven write waits
    initial begin
        repeat (80000) @(posedge clock_in);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule
